// ===== verilog/amrcp_consts.vh
// command codes, property addresses, reset values and status layout
// included by the receiver command block; definitions only
`ifndef AMRCP_CONSTS_VH
`define AMRCP_CONSTS_VH
// command bytes
`define CMD_POWER_UP     8'h01
`define CMD_REV_QUERY    8'h10
`define CMD_POWER_DOWN   8'h11
`define CMD_PROP_WRITE   8'h12
`define CMD_PROP_READ    8'h13
`define CMD_IRQ_STATUS   8'h14
`define CMD_PATCH_ARG    8'h15
`define CMD_PATCH_DATA   8'h16
`define CMD_TUNE         8'h40
`define CMD_SEARCH       8'h41
`define CMD_TUNE_QUERY   8'h42
`define CMD_QUAL_QUERY   8'h43
`define CMD_OUT_DRIVE    8'h80
`define CMD_OUT_LEVEL    8'h81
// power-up function codes
`define FUNC_RECEIVE     4'h1
`define FUNC_LIB_QUERY   4'hF
// status byte bits
`define ST_CTS           7
`define ST_ERR           6
`define ST_QUAL          3
`define ST_DONE          0
// property addresses
`define P_IRQ_EN         16'h0001
`define P_DAF            16'h0102
`define P_DSR            16'h0104
`define P_REF_FREQ       16'h0201
`define P_REF_PRE        16'h0202
`define P_DEEMPH         16'h3100
`define P_CHAN_BW        16'h3102
`define P_QIRQ_CFG       16'h3200
`define P_NR_HI          16'h3201
`define P_NR_LO          16'h3202
`define P_ST_HI          16'h3203
`define P_ST_LO          16'h3204
`define P_SM_RATE        16'h3300
`define P_SM_SLOPE       16'h3301
`define P_SM_MAX         16'h3302
`define P_SM_NOISE       16'h3303
`define P_BAND_LO        16'h3400
`define P_BAND_HI        16'h3401
`define P_STEP           16'h3402
`define P_SRCH_NR        16'h3403
`define P_SRCH_ST        16'h3404
`define P_VOLUME         16'h4000
`define P_HMUTE          16'h4001
`define P_GAIN_REL       16'h4101
// reset values
`define R_REF_FREQ       16'h8000
`define R_REF_PRE        16'h0001
`define R_CHAN_BW        16'h0003
`define R_THR_HI         16'h007F
`define R_SM_RATE        16'h0040
`define R_SM_SLOPE       16'h0002
`define R_SM_MAX         16'h0010
`define R_SM_NOISE       16'h000A
`define R_BAND_LO        16'h0208
`define R_BAND_HI        16'h06AE
`define R_STEP           16'h000A
`define R_SRCH_NR        16'h0005
`define R_SRCH_ST        16'h0019
`define R_VOLUME         16'h003F
`define R_GAIN_REL       16'h008C
// value limits
`define GAIN_REL_MIN     16'h0004
`define GAIN_REL_MAX     16'h00F8
`define REF_FREQ_MIN     16'h799A
`define REF_FREQ_MAX     16'h8666
`define CHAN_BW_MAX      16'h0006
// store size
`define PROP_COUNT       24
`define PROP_NONE        5'h1F
`endif

// ===== verilog/amrcp_core.v
// command decoder and property store of the am receiver function
// commands arrive on a parallel port from same-clock logic; tuner events are asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "amrcp_consts.vh"

// Function
// - gain release rate accepts 4..248 in steps of 4, resets to 140
// - clear-to-send rises once a command, including property write, is handled
// - decode 0x01 power up, 0x10 revision, 0x11 power down
// - decode 0x12 property write, 0x13 property read, 0x14 interrupt status
// - 0x15 and 0x16 reserved for patch argument and data transfer
// - decode 0x40 tune, 0x41 search, 0x42 tune or search status
// - decode 0x43 signal quality query for current channel
// - 0x80 sets output drive, 0x81 output levels, firmware 2.0 and later
// - reference frequency 0 or 31130..34406 Hz, resets to 0x8000
// - reference prescaler at 0x0202 resets to 0x0001
// - channel bandwidth at 0x3102 resets to code 3; 1 kHz (code 6) needs BW_1K_OK set
// - de-emphasis at 0x3100 resets to disabled
// - quality interrupt config resets disabled, high limits 0x7F, low limits 0
// - soft mute max 16 dB, zero disables; rate 0x40, noise limit 10
// - search band 520..1710 kHz, step 10 kHz at reset
// - zero noise-ratio search threshold ignores that criterion; resets to 5
// - zero strength search threshold ignores that criterion; resets to 25
// - volume resets to 0x3F; hard mute mutes left and right outputs
// - digital format and sample rate reset to zero, firmware 2.0 and later
// - status bit 7 clear-to-send, bit 6 error
// - status bit 3 quality interrupt, bit 0 tune or search complete
module amrcp_core #(
    parameter [7:0] FW_MAJOR  = 8'h32,   // ascii firmware major, arbitrary
    parameter [7:0] FW_MINOR  = 8'h30,   // ascii firmware minor, arbitrary
    parameter [7:0] PART_CODE = 8'h5A,   // part number code, arbitrary
    parameter [7:0] LIB_ID    = 8'h01,   // library code, arbitrary
    parameter [0:0] BW_1K_OK  = 1'b1     // narrowest bandwidth code available
) (
    // clock and reset
    input  wire        clk_in,
    input  wire        resetn_in,
    // command port
    input  wire        cmd_valid_in,
    input  wire [7:0]  cmd_byte_in,
    input  wire [7:0]  cmd_arg_in,
    input  wire [15:0] prop_addr_in,
    input  wire [15:0] prop_data_in,
    // tuner events and metrics
    input  wire        tune_done_in,
    input  wire        quality_trig_in,
    input  wire [7:0]  noise_ratio_in,
    input  wire [7:0]  strength_in,
    // response
    output wire [7:0]  status_out,
    output reg         resp_valid_out,
    output reg  [15:0] resp_data_out,
    // device state
    output reg         powered_out,
    output reg         tuning_out,
    output reg         channel_valid_out,
    output reg  [2:0]  general_out_oe_out,
    output reg  [2:0]  general_out_level_out,
    output wire [5:0]  volume_out,
    output wire        mute_left_out,
    output wire        mute_right_out
);

    // =========================================================
    // decode helpers
    function [4:0] prop_idx;
        input [15:0] a;
        begin
            case (a)
                `P_IRQ_EN:   prop_idx = 5'd0;
                `P_DAF:      prop_idx = 5'd1;
                `P_DSR:      prop_idx = 5'd2;
                `P_REF_FREQ: prop_idx = 5'd3;
                `P_REF_PRE:  prop_idx = 5'd4;
                `P_DEEMPH:   prop_idx = 5'd5;
                `P_CHAN_BW:  prop_idx = 5'd6;
                `P_QIRQ_CFG: prop_idx = 5'd7;
                `P_NR_HI:    prop_idx = 5'd8;
                `P_NR_LO:    prop_idx = 5'd9;
                `P_ST_HI:    prop_idx = 5'd10;
                `P_ST_LO:    prop_idx = 5'd11;
                `P_SM_RATE:  prop_idx = 5'd12;
                `P_SM_SLOPE: prop_idx = 5'd13;
                `P_SM_MAX:   prop_idx = 5'd14;
                `P_SM_NOISE: prop_idx = 5'd15;
                `P_BAND_LO:  prop_idx = 5'd16;
                `P_BAND_HI:  prop_idx = 5'd17;
                `P_STEP:     prop_idx = 5'd18;
                `P_SRCH_NR:  prop_idx = 5'd19;
                `P_SRCH_ST:  prop_idx = 5'd20;
                `P_VOLUME:   prop_idx = 5'd21;
                `P_HMUTE:    prop_idx = 5'd22;
                `P_GAIN_REL: prop_idx = 5'd23;
                default:     prop_idx = `PROP_NONE;
            endcase
        end
    endfunction

    function [15:0] prop_rst;
        input [4:0] i;
        begin
            case (i)
                5'd3:    prop_rst = `R_REF_FREQ;
                5'd4:    prop_rst = `R_REF_PRE;
                5'd6:    prop_rst = `R_CHAN_BW;
                5'd8:    prop_rst = `R_THR_HI;
                5'd10:   prop_rst = `R_THR_HI;
                5'd12:   prop_rst = `R_SM_RATE;
                5'd13:   prop_rst = `R_SM_SLOPE;
                5'd14:   prop_rst = `R_SM_MAX;
                5'd15:   prop_rst = `R_SM_NOISE;
                5'd16:   prop_rst = `R_BAND_LO;
                5'd17:   prop_rst = `R_BAND_HI;
                5'd18:   prop_rst = `R_STEP;
                5'd19:   prop_rst = `R_SRCH_NR;
                5'd20:   prop_rst = `R_SRCH_ST;
                5'd21:   prop_rst = `R_VOLUME;
                5'd23:   prop_rst = `R_GAIN_REL;
                default: prop_rst = 16'h0000;
            endcase
        end
    endfunction

    // =========================================================
    // synchronisers for tuner side
    reg  [2:0]  done_sync_ff;
    reg  [2:0]  qual_sync_ff;
    reg  [7:0]  nr_meta_ff;
    reg  [7:0]  nr_ff;
    reg  [7:0]  st_meta_ff;
    reg  [7:0]  st_ff;

    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            done_sync_ff <= 3'h0;
            qual_sync_ff <= 3'h0;
            nr_meta_ff   <= 8'h00;
            nr_ff        <= 8'h00;
            st_meta_ff   <= 8'h00;
            st_ff        <= 8'h00;
        end else begin
            done_sync_ff <= {done_sync_ff[1:0], tune_done_in};
            qual_sync_ff <= {qual_sync_ff[1:0], quality_trig_in};
            nr_meta_ff   <= noise_ratio_in;
            nr_ff        <= nr_meta_ff;
            st_meta_ff   <= strength_in;
            st_ff        <= st_meta_ff;
        end
    end

    wire done_evt = done_sync_ff[1] & ~done_sync_ff[2];
    wire qual_evt = qual_sync_ff[1] & ~qual_sync_ff[2];

    // =========================================================
    // command state
    localparam [0:0] S_IDLE = 1'b0;
    localparam [0:0] S_EXEC = 1'b1;

    reg         state_ff;
    reg  [7:0]  cmd_ff;
    reg  [7:0]  arg_ff;
    reg  [15:0] addr_ff;
    reg  [15:0] data_ff;
    reg         cts_ff;
    reg         err_ff;
    reg         done_flag_ff;
    reg         qual_flag_ff;
    reg  [15:0] prop_ff [0:`PROP_COUNT-1];

    wire        fw2 = (FW_MAJOR >= 8'h32);
    wire [4:0]  idx = prop_idx(addr_ff);
    wire [15:0] rd_val = (idx == `PROP_NONE) ? 16'h0000 : prop_ff[idx];

    // value check per property
    reg         val_ok;
    always @* begin
        val_ok = 1'b1;
        case (idx)
            5'd1, 5'd2: val_ok = fw2;
            5'd3: val_ok = (data_ff == 16'h0000) ||
                           ((data_ff >= `REF_FREQ_MIN) && (data_ff <= `REF_FREQ_MAX));
            5'd6: val_ok = (data_ff <= `CHAN_BW_MAX) &&
                           (BW_1K_OK || (data_ff != `CHAN_BW_MAX));
            5'd23: val_ok = (data_ff >= `GAIN_REL_MIN) && (data_ff <= `GAIN_REL_MAX) &&
                            (data_ff[1:0] == 2'b00);
            `PROP_NONE: val_ok = 1'b0;
            default: val_ok = 1'b1;
        endcase
    end

    // =========================================================
    // execute decode
    reg         nxt_err;
    reg         nxt_powered;
    reg         nxt_tuning;
    reg         prop_wr;
    reg         prop_dflt;
    reg         clr_done;
    reg         clr_qual;
    reg  [15:0] nxt_resp;
    reg  [2:0]  nxt_oe;
    reg  [2:0]  nxt_lvl;

    always @* begin
        nxt_err     = 1'b0;
        nxt_powered = powered_out;
        nxt_tuning  = tuning_out;
        prop_wr     = 1'b0;
        prop_dflt   = 1'b0;
        clr_done    = 1'b0;
        clr_qual    = 1'b0;
        nxt_resp    = 16'h0000;
        nxt_oe      = general_out_oe_out;
        nxt_lvl     = general_out_level_out;
        case (cmd_ff)
            `CMD_POWER_UP: begin
                if (powered_out)
                    nxt_err = 1'b1;
                else if (arg_ff[3:0] == `FUNC_RECEIVE)
                    nxt_powered = 1'b1;
                else if (arg_ff[3:0] == `FUNC_LIB_QUERY)
                    nxt_resp = {PART_CODE, LIB_ID};
                else
                    nxt_err = 1'b1;
            end
            `CMD_REV_QUERY: nxt_resp = {FW_MAJOR, FW_MINOR};
            `CMD_POWER_DOWN: begin
                nxt_powered = 1'b0;
                nxt_tuning  = 1'b0;
                prop_dflt   = 1'b1;
                nxt_oe      = 3'h0;
                nxt_lvl     = 3'h0;
            end
            `CMD_PROP_WRITE: begin
                if (!powered_out || !val_ok)
                    nxt_err = 1'b1;
                else
                    prop_wr = 1'b1;
            end
            `CMD_PROP_READ: begin
                if (!powered_out || (idx == `PROP_NONE))
                    nxt_err = 1'b1;
                else
                    nxt_resp = rd_val;
            end
            `CMD_IRQ_STATUS: begin
                clr_done = arg_ff[0];
                clr_qual = arg_ff[0];
            end
            `CMD_PATCH_ARG, `CMD_PATCH_DATA: nxt_err = powered_out;
            `CMD_TUNE, `CMD_SEARCH: begin
                if (!powered_out)
                    nxt_err = 1'b1;
                else
                    nxt_tuning = 1'b1;
            end
            `CMD_TUNE_QUERY: begin
                nxt_err  = !powered_out;
                clr_done = arg_ff[0];
                nxt_resp = {7'h00, channel_valid_out, 7'h00, tuning_out};
            end
            `CMD_QUAL_QUERY: begin
                nxt_err  = !powered_out;
                clr_qual = arg_ff[0];
                nxt_resp = {st_ff, nr_ff};
            end
            `CMD_OUT_DRIVE: begin
                if (!powered_out || !fw2)
                    nxt_err = 1'b1;
                else
                    nxt_oe = arg_ff[3:1];
            end
            `CMD_OUT_LEVEL: begin
                if (!powered_out || !fw2)
                    nxt_err = 1'b1;
                else
                    nxt_lvl = arg_ff[3:1];
            end
            default: nxt_err = 1'b1;
        endcase
    end

    wire exec = (state_ff == S_EXEC);

    // =========================================================
    // sequencing and status
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_ff              <= S_IDLE;
            cmd_ff                <= 8'h00;
            arg_ff                <= 8'h00;
            addr_ff               <= 16'h0000;
            data_ff               <= 16'h0000;
            cts_ff                <= 1'b1;
            err_ff                <= 1'b0;
            resp_valid_out        <= 1'b0;
            resp_data_out         <= 16'h0000;
            powered_out           <= 1'b0;
            tuning_out            <= 1'b0;
            general_out_oe_out    <= 3'h0;
            general_out_level_out <= 3'h0;
        end else begin
            resp_valid_out <= 1'b0;
            case (state_ff)
                S_IDLE: begin
                    if (cmd_valid_in && cts_ff) begin
                        state_ff <= S_EXEC;
                        cts_ff   <= 1'b0;
                        cmd_ff   <= cmd_byte_in;
                        arg_ff   <= cmd_arg_in;
                        addr_ff  <= prop_addr_in;
                        data_ff  <= prop_data_in;
                    end
                end
                S_EXEC: begin
                    state_ff              <= S_IDLE;
                    cts_ff                <= 1'b1;
                    err_ff                <= nxt_err;
                    resp_valid_out        <= 1'b1;
                    resp_data_out         <= nxt_resp;
                    powered_out           <= nxt_powered;
                    general_out_oe_out    <= nxt_oe;
                    general_out_level_out <= nxt_lvl;
                end
                default: state_ff <= S_IDLE;
            endcase
            if (exec)
                tuning_out <= nxt_tuning;
            else if (done_evt)
                tuning_out <= 1'b0;
        end
    end

    // event flags: a set in the same cycle as a clear wins
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            done_flag_ff <= 1'b0;
            qual_flag_ff <= 1'b0;
        end else begin
            if (done_evt && powered_out)
                done_flag_ff <= 1'b1;
            else if (exec && clr_done)
                done_flag_ff <= 1'b0;
            if (qual_evt && powered_out && (prop_ff[7] != 16'h0000))
                qual_flag_ff <= 1'b1;
            else if (exec && clr_qual)
                qual_flag_ff <= 1'b0;
        end
    end

    assign status_out = {cts_ff, err_ff, 2'b00, qual_flag_ff, 2'b00, done_flag_ff};

    // =========================================================
    // property store
    genvar gi;
    generate
        for (gi = 0; gi < `PROP_COUNT; gi = gi + 1) begin : g_prop
            localparam [4:0] SLOT = gi;
            always @(posedge clk_in or negedge resetn_in) begin
                if (!resetn_in)
                    prop_ff[gi] <= prop_rst(SLOT);
                else if (exec && prop_dflt)
                    prop_ff[gi] <= prop_rst(SLOT);
                else if (exec && prop_wr && (idx == SLOT))
                    prop_ff[gi] <= data_ff;
            end
        end
    endgenerate

    // =========================================================
    // channel validity against search thresholds
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in)
            channel_valid_out <= 1'b0;
        else
            channel_valid_out <= powered_out &&
                ((prop_ff[19] == 16'h0000) || ({8'h00, nr_ff} >= prop_ff[19])) &&
                ((prop_ff[20] == 16'h0000) || ({8'h00, st_ff} >= prop_ff[20]));
    end

    assign volume_out     = prop_ff[21][5:0];
    assign mute_left_out  = prop_ff[22][1];
    assign mute_right_out = prop_ff[22][0];

endmodule // amrcp_core
`default_nettype wire

// ===== tb/amrcp_core_sva.sv
// ==========================================
// checker of command timing and property effects
// bound into amrcp_core, sees its ports only
`timescale 1ns/1ps
`default_nettype none
`include "amrcp_consts.vh"
module amrcp_sva (
    // clock, reset, command
    input wire logic        clk_in,
    input wire logic        resetn_in,
    input wire logic        cmd_valid_in,
    input wire logic [7:0]  cmd_byte_in,
    input wire logic [7:0]  cmd_arg_in,
    input wire logic [15:0] prop_addr_in,
    input wire logic [15:0] prop_data_in,
    // response and state
    input wire logic [7:0]  status_out,
    input wire logic        resp_valid_out,
    input wire logic        powered_out,
    input wire logic [5:0]  volume_out,
    input wire logic        mute_left_out,
    input wire logic        mute_right_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    wire take = cmd_valid_in && status_out[`ST_CTS];
    wire wr = take && powered_out && cmd_byte_in == `CMD_PROP_WRITE;
    a_cts_busy: assert property (
        take |=> !status_out[7] ##1 status_out[7]) else $error("cts low time wrong");
    a_resp_once: assert property (
        take |=> !resp_valid_out ##1 resp_valid_out ##1 !resp_valid_out)
        else $error("completion pulse misplaced");
    a_undef_err: assert property (
        take && (cmd_byte_in == 8'h00 || cmd_byte_in[7:6] == 2'b11) |-> ##2 status_out[6])
        else $error("unknown command accepted");
    a_power_up: assert property (
        take && !powered_out && cmd_byte_in == `CMD_POWER_UP && cmd_arg_in[3:0] == `FUNC_RECEIVE
        |-> ##2 powered_out && !status_out[6]) else $error("power-up failed");
    a_power_down: assert property (
        take && cmd_byte_in == `CMD_POWER_DOWN |-> ##2 !powered_out && volume_out == 6'h3F)
        else $error("power-down wrong");
    a_volume_set: assert property (
        wr && prop_addr_in == `P_VOLUME |-> ##2 volume_out == $past(prop_data_in[5:0], 2))
        else $error("volume not applied");
    a_mute_set: assert property (
        wr && prop_addr_in == `P_HMUTE
        |-> ##2 {mute_left_out, mute_right_out} == $past(prop_data_in[1:0], 2))
        else $error("mute not applied");
    a_locked_store: assert property (
        take && !powered_out && cmd_byte_in == `CMD_PROP_WRITE
        |=> $stable(volume_out) [*2] ##0 status_out[6]) else $error("store changed while down");
    a_gain_range: assert property (
        wr && prop_addr_in == `P_GAIN_REL && (prop_data_in[1:0] != 2'b00 || prop_data_in > 16'h00F8)
        |-> ##2 status_out[6]) else $error("bad release rate accepted");
endmodule // amrcp_sva
bind amrcp_core amrcp_sva u_sva (.clk_in(clk_in), .resetn_in(resetn_in),
    .cmd_valid_in(cmd_valid_in), .cmd_byte_in(cmd_byte_in), .cmd_arg_in(cmd_arg_in),
    .prop_addr_in(prop_addr_in), .prop_data_in(prop_data_in), .status_out(status_out),
    .resp_valid_out(resp_valid_out), .powered_out(powered_out), .volume_out(volume_out),
    .mute_left_out(mute_left_out), .mute_right_out(mute_right_out));
`default_nettype wire

// ===== tb/amrcp_ctl.sv
// ==========================================
// controller model: one command at a time
// assumes status and completion pulse of the core
`timescale 1ns/1ps
`default_nettype none
module amrcp_ctl (
    // clock and answer
    input  wire logic        clk_in,
    input  wire logic [7:0]  status_in,
    input  wire logic        resp_valid_in,
    // request
    output var  logic        cmd_valid_out,
    output var  logic [7:0]  cmd_byte_out,
    output var  logic [7:0]  cmd_arg_out,
    output var  logic [15:0] prop_addr_out,
    output var  logic [15:0] prop_data_out
);
    initial {cmd_valid_out, cmd_byte_out, cmd_arg_out, prop_addr_out, prop_data_out} = '0;
    task automatic issue(input logic [7:0] c, input logic [7:0] a, input logic [15:0] pa,
                         input logic [15:0] pd, output logic ok);
        int n = 0;
        while (status_in[7] !== 1'b1 && n < 40) begin
            @(posedge clk_in);
            n++;
        end
        cmd_valid_out <= 1'b1;
        cmd_byte_out  <= c;
        cmd_arg_out   <= a;
        prop_addr_out <= pa;
        prop_data_out <= pd;
        @(posedge clk_in);
        cmd_valid_out <= 1'b0;
        prop_addr_out <= ~pa;
        prop_data_out <= ~pd;
        do begin
            @(posedge clk_in);
            n++;
        end while (resp_valid_in !== 1'b1 && n < 40);
        ok = (n < 40);
    endtask
endmodule // amrcp_ctl
`default_nettype wire

// ===== tb/tb.sv
// ==========================================
// bench for the receiver command core
// commands via controller model; tuner side driven here
`timescale 1ns/1ps
`default_nettype none
`include "amrcp_consts.vh"
module tb;
    localparam logic [7:0] PC = 8'h5A, LB = 8'h01; // arbitrary part and library codes
    localparam logic [7:0] FJ = 8'h32, FN = 8'h30; // arbitrary revision codes
    logic        clk_in = 1'b0, resetn_in = 1'b0, tune_done_in = 1'b0, quality_trig_in = 1'b0;
    logic [7:0]  noise_ratio_in = 8'h0A, strength_in = 8'h1E;
    wire         cmd_valid, resp_valid, powered, tuning, chan_ok, ml, mr;
    wire [7:0]   cmd_byte, cmd_arg, status;
    wire [15:0]  prop_addr, prop_data, resp_data;
    wire [2:0]   oe, lvl;
    wire [5:0]   volume;
    int          err_total = 0, checked = 0;
    logic [31:0] seed = 32'h513FC717;
    logic        ok;
    logic [15:0] mdl [24];
    logic [7:0]  bad [5] = '{8'h00, 8'h17, 8'hC5, 8'h15, 8'h16};
    logic [31:0] cv [8] = '{32'h0017_0000, 32'h0017_0006, 32'h0017_00F8, 32'h0017_00FC,
        32'h0003_7999, 32'h0003_799A, 32'h0003_8667, 32'h0006_0007};
    logic [31:0] rt [24] = '{32'h0001_0000, 32'h0102_0000, 32'h0104_0000, 32'h0201_8000,
        32'h0202_0001, 32'h3100_0000, 32'h3102_0003, 32'h3200_0000, 32'h3201_007F,
        32'h3202_0000, 32'h3203_007F, 32'h3204_0000, 32'h3300_0040, 32'h3301_0002,
        32'h3302_0010, 32'h3303_000A, 32'h3400_0208, 32'h3401_06AE, 32'h3402_000A,
        32'h3403_0005, 32'h3404_0019, 32'h4000_003F, 32'h4001_0000, 32'h4101_008C};
    amrcp_ctl ctl (.clk_in(clk_in), .status_in(status), .resp_valid_in(resp_valid),
        .cmd_valid_out(cmd_valid), .cmd_byte_out(cmd_byte), .cmd_arg_out(cmd_arg),
        .prop_addr_out(prop_addr), .prop_data_out(prop_data));
    amrcp_core #(.FW_MAJOR(FJ), .FW_MINOR(FN), .PART_CODE(PC), .LIB_ID(LB)) dut (
        .clk_in(clk_in), .resetn_in(resetn_in), .cmd_valid_in(cmd_valid),
        .cmd_byte_in(cmd_byte), .cmd_arg_in(cmd_arg), .prop_addr_in(prop_addr),
        .prop_data_in(prop_data), .tune_done_in(tune_done_in),
        .quality_trig_in(quality_trig_in), .noise_ratio_in(noise_ratio_in),
        .strength_in(strength_in), .status_out(status), .resp_valid_out(resp_valid),
        .resp_data_out(resp_data), .powered_out(powered), .tuning_out(tuning),
        .channel_valid_out(chan_ok), .general_out_oe_out(oe), .general_out_level_out(lvl),
        .volume_out(volume), .mute_left_out(ml), .mute_right_out(mr));
    initial forever #25 clk_in = ~clk_in;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic legal(input logic [15:0] a, input logic [15:0] v);
        if (a == `P_GAIN_REL) return v >= 16'h0004 && v <= 16'h00F8 && v[1:0] == 2'b00;
        if (a == `P_REF_FREQ) return v == 16'h0000 || (v >= 16'h799A && v <= 16'h8666);
        return a != `P_CHAN_BW || v <= 16'h0006;
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] c, input logic [7:0] a, input logic [15:0] pa,
                       input logic [15:0] pd, input logic e);
        ctl.issue(c, a, pa, pd, ok);
        if (!ok) begin
            err_total++;
            report_and_stop();
        end
        chk({15'h0000, status[6]}, {15'h0000, e});
    endtask
    task automatic rd(input int i);
        cmd(`CMD_PROP_READ, 8'h00, rt[i][31:16], 16'h0000, 1'b0);
        chk(resp_data, mdl[i]);
    endtask
    task automatic wr(input int i, input logic [15:0] v);
        logic e;
        e = !legal(rt[i][31:16], v);
        cmd(`CMD_PROP_WRITE, 8'h00, rt[i][31:16], v, e);
        if (!e)
            mdl[i] = v;
        rd(i);
        chk({8'h00, volume, ml, mr}, {8'h00, mdl[21][5:0], mdl[22][1:0]});
    endtask
    task automatic resets();
        for (int i = 0; i < 24; i++)
            mdl[i] = rt[i][15:0];
        for (int i = 0; i < 11; i++)
            rd(i);
        for (int i = 11; i < 24; i++)
            rd(i);
    endtask
    task automatic report_and_stop();
        $display("counts: %0d checks, %0d mismatches", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_in);
        resetn_in <= 1'b1;
        @(posedge clk_in);
        chk({8'h00, status}, 16'h0080);
        cmd(`CMD_PROP_WRITE, 8'h00, `P_VOLUME, 16'h0005, 1'b1);
        chk({10'h000, volume}, 16'h003F);
        cmd(`CMD_POWER_UP, 8'h0F, 16'h0000, 16'h0000, 1'b0);
        chk(resp_data, {PC, LB});
        chk({15'h0000, powered}, 16'h0000);
        cmd(`CMD_REV_QUERY, 8'h00, 16'h0000, 16'h0000, 1'b0);
        chk(resp_data, {FJ, FN});
        cmd(`CMD_POWER_UP, 8'h01, 16'h0000, 16'h0000, 1'b0);
        resets();
        $display("test done: power and defaults");
        cmd(`CMD_TUNE, 8'h00, 16'h0000, 16'h0000, 1'b0);
        chk({15'h0000, tuning}, 16'h0001);
        tune_done_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        chk({8'h00, status & 8'h81}, 16'h0081);
        cmd(`CMD_TUNE_QUERY, 8'h01, 16'h0000, 16'h0000, 1'b0);
        chk(resp_data, 16'h0100);
        wr(7, 16'h0001);
        quality_trig_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        cmd(`CMD_QUAL_QUERY, 8'h00, 16'h0000, 16'h0000, 1'b0);
        chk(resp_data, {strength_in, noise_ratio_in});
        chk({8'h00, status & 8'h09}, 16'h0008);
        cmd(`CMD_IRQ_STATUS, 8'h01, 16'h0000, 16'h0000, 1'b0);
        chk({8'h00, status & 8'h09}, 16'h0000);
        noise_ratio_in <= 8'h00;
        repeat (4) @(posedge clk_in);
        chk({15'h0000, chan_ok}, 16'h0000);
        wr(19, 16'h0000);
        chk({15'h0000, chan_ok}, 16'h0001);
        strength_in <= 8'h00;
        repeat (4) @(posedge clk_in);
        chk({15'h0000, chan_ok}, 16'h0000);
        wr(20, 16'h0000);
        chk({15'h0000, chan_ok}, 16'h0001);
        $display("test done: events");
        cmd(`CMD_OUT_DRIVE, 8'h0A, 16'h0000, 16'h0000, 1'b0);
        cmd(`CMD_OUT_LEVEL, 8'h0C, 16'h0000, 16'h0000, 1'b0);
        chk({10'h000, oe, lvl}, 16'h002E);
        foreach (bad[k])
            cmd(bad[k], 8'h00, 16'h0000, 16'h0000, 1'b1);
        wr(17, 16'h06AE);
        wr(16, 16'h0099);
        wr(17, 16'h0117);
        wr(18, 16'h0009);
        foreach (cv[k])
            wr(cv[k][31:16], cv[k][15:0]);
        repeat (80) begin
            seed = xs(seed);
            wr(seed[15:0] % 24, seed[31] ? seed[31:16] : {8'h00, seed[23:18], 2'b00});
        end
        $display("test done: property writes");
        cmd(`CMD_POWER_DOWN, 8'h00, 16'h0000, 16'h0000, 1'b0);
        chk({7'h00, powered, volume, ml, mr}, 16'h00FC);
        cmd(`CMD_POWER_UP, 8'h01, 16'h0000, 16'h0000, 1'b0);
        resets();
        $display("test done: power-down defaults");
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
